//--- aga_mod_adder.sv
`timescale 1ns/1ps
package aga_pkg;
  localparam int ADDR_W    = 32;
  localparam int HALF_W    = 16;
  localparam int BYTE_W    = 8;
  localparam int SHIFT_ONE = 1;
  localparam int SHIFT_TWO = 2;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h00000000;
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 32'h00000001;
  localparam logic              FLAG_RST  = 1'b0;

  typedef enum logic [4:0] {
    OP_ADDR_ADD,
    OP_ADDR_ADD_SHIFT_ONE,
    OP_ADDR_ADD_SHIFT_TWO,
    OP_ADDR_SUB,
    OP_ADDR_INC,
    OP_ADDR_DEC,
    OP_ADDR_TFR,
    OP_ADDR_ARITH_LEFT_TWO,
    OP_ADDR_ARITH_LEFT,
    OP_ADDR_ARITH_RIGHT,
    OP_ADDR_LOGIC_RIGHT,
    OP_ADDR_COMPARE_EQUAL,
    OP_ADDR_COMPARE_GREATER,
    OP_ADDR_COMPARE_HIGHER,
    OP_ADDR_DEC_FLAG_ZERO,
    OP_ADDR_DEC_FLAG_NONNEG,
    OP_ADDR_TEST_ZERO,
    OP_ADDR_TEST_ZERO_LOW_HALF,
    OP_ADDR_TEST_NONNEG,
    OP_ADDR_TEST_POSITIVE,
    OP_ADDR_SIGN_EXT_BYTE,
    OP_ADDR_SIGN_EXT_HALF,
    OP_ADDR_ZERO_EXT_BYTE,
    OP_ADDR_ZERO_EXT_HALF
  } aga_op_t;

  typedef enum logic [1:0] {
    MODE_LINEAR,
    MODE_REVERSE_CARRY,
    MODE_MODULO
  } aga_mode_t;
endpackage

module aga_mod_adder (
  input  wire logic [aga_pkg::ADDR_W-1:0] addr,
  input  wire logic [aga_pkg::ADDR_W-1:0] offset,
  input  wire aga_pkg::aga_mode_t         mode,
  input  wire logic [aga_pkg::ADDR_W-1:0] mod_base,
  input  wire logic [aga_pkg::ADDR_W-1:0] mod_len,
  output logic      [aga_pkg::ADDR_W-1:0] sum
);
  import aga_pkg::*;

  function automatic logic [ADDR_W-1:0] bit_rev(input logic [ADDR_W-1:0] v);
    logic [ADDR_W-1:0] r;
    r = ADDR_ZERO;
    for (int i = 0; i < ADDR_W; i++) begin
      r[i] = v[ADDR_W-1-i];
    end
    return r;
  endfunction

  logic [ADDR_W-1:0] plain_sum;
  logic [ADDR_W-1:0] upper;

  assign plain_sum = addr + offset;
  assign upper     = mod_base + mod_len;

  always_comb begin
    case (mode)
      MODE_LINEAR:        sum = plain_sum;
      // Carry runs from msb down, as for FFT buffer walks
      MODE_REVERSE_CARRY: sum = bit_rev(bit_rev(addr) + bit_rev(offset));
      // Wraps one length only; offsets beyond the buffer length are not folded
      MODE_MODULO: begin
        if (plain_sum >= upper) begin
          sum = plain_sum - mod_len;
        end else if (plain_sum < mod_base) begin
          sum = plain_sum + mod_len;
        end else begin
          sum = plain_sum;
        end
      end
      default:            sum = plain_sum;
    endcase
  end
endmodule

//--- aga_arith.sv
// Function
// - Address add shaped by modifier mode
// - Add with source shifted left one
// - Add with source shifted left two
// - Arithmetic left shift by two bits
// - Arithmetic right and left shift by one
// - Logical right shift, zero fill msb
// - Decrement, flag set when result zero
// - Decrement, flag set when result nonnegative
// - Compare equal, signed greater, unsigned higher
// - Test zero, full or low half
// - Signed test nonnegative and positive
`timescale 1ns/1ps
module aga_arith (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        clk_en,
  input  wire logic                        op_valid,
  input  wire aga_pkg::aga_op_t            op_code,
  input  wire logic [aga_pkg::ADDR_W-1:0]  src_a,
  input  wire logic [aga_pkg::ADDR_W-1:0]  src_b,
  input  wire aga_pkg::aga_mode_t          mod_mode,
  input  wire logic [aga_pkg::ADDR_W-1:0]  mod_base,
  input  wire logic [aga_pkg::ADDR_W-1:0]  mod_len,
  output logic      [aga_pkg::ADDR_W-1:0]  result_r,
  output logic                             result_we_r,
  output logic                             true_flag_r,
  output logic                             done_r
);
  import aga_pkg::*;

  logic [ADDR_W-1:0] result_nxt;
  logic              result_we_nxt;
  logic              true_flag_nxt;
  logic              done_nxt;
  logic [ADDR_W-1:0] add_offset;
  logic [ADDR_W-1:0] mod_sum;
  logic [ADDR_W-1:0] dec_val;
  logic              issue;

  assign issue   = clk_en && op_valid;
  assign dec_val = src_a - ADDR_ONE;

  // Source is shifted before the mode adder
  always_comb begin
    case (op_code)
      OP_ADDR_ADD_SHIFT_ONE: add_offset = src_b << SHIFT_ONE;
      OP_ADDR_ADD_SHIFT_TWO: add_offset = src_b << SHIFT_TWO;
      default:               add_offset = src_b;
    endcase
  end

  aga_mod_adder u_mod_adder (
    .addr     (src_a),
    .offset   (add_offset),
    .mode     (mod_mode),
    .mod_base (mod_base),
    .mod_len  (mod_len),
    .sum      (mod_sum)
  );

  always_comb begin
    result_nxt    = result_r;
    true_flag_nxt = true_flag_r;
    result_we_nxt = 1'b0;
    done_nxt      = 1'b0;
    if (op_valid) begin
      done_nxt      = 1'b1;
      result_we_nxt = 1'b1;
      case (op_code)
        OP_ADDR_ADD,
        OP_ADDR_ADD_SHIFT_ONE,
        OP_ADDR_ADD_SHIFT_TWO:  result_nxt = mod_sum;
        OP_ADDR_SUB:            result_nxt = src_a - src_b;
        OP_ADDR_INC:            result_nxt = src_a + ADDR_ONE;
        OP_ADDR_DEC:            result_nxt = dec_val;
        OP_ADDR_TFR:            result_nxt = src_a;
        OP_ADDR_ARITH_LEFT_TWO: result_nxt = src_a << SHIFT_TWO;
        OP_ADDR_ARITH_LEFT:     result_nxt = src_a << SHIFT_ONE;
        OP_ADDR_ARITH_RIGHT:    result_nxt = {src_a[ADDR_W-1], src_a[ADDR_W-1:1]};
        OP_ADDR_LOGIC_RIGHT:    result_nxt = {1'b0, src_a[ADDR_W-1:1]};
        OP_ADDR_DEC_FLAG_ZERO: begin
          result_nxt    = dec_val;
          true_flag_nxt = (dec_val == ADDR_ZERO);
        end
        OP_ADDR_DEC_FLAG_NONNEG: begin
          result_nxt    = dec_val;
          true_flag_nxt = !dec_val[ADDR_W-1];
        end
        OP_ADDR_COMPARE_EQUAL: begin
          result_we_nxt = 1'b0;
          true_flag_nxt = (src_a == src_b);
        end
        OP_ADDR_COMPARE_GREATER: begin
          result_we_nxt = 1'b0;
          true_flag_nxt = ($signed(src_a) > $signed(src_b));
        end
        OP_ADDR_COMPARE_HIGHER: begin
          result_we_nxt = 1'b0;
          true_flag_nxt = (src_a > src_b);
        end
        OP_ADDR_TEST_ZERO: begin
          result_we_nxt = 1'b0;
          true_flag_nxt = (src_a == ADDR_ZERO);
        end
        OP_ADDR_TEST_ZERO_LOW_HALF: begin
          result_we_nxt = 1'b0;
          true_flag_nxt = (src_a[HALF_W-1:0] == ADDR_ZERO[HALF_W-1:0]);
        end
        OP_ADDR_TEST_NONNEG: begin
          result_we_nxt = 1'b0;
          true_flag_nxt = !src_a[ADDR_W-1];
        end
        OP_ADDR_TEST_POSITIVE: begin
          result_we_nxt = 1'b0;
          true_flag_nxt = !src_a[ADDR_W-1] && (src_a != ADDR_ZERO);
        end
        OP_ADDR_SIGN_EXT_BYTE:
          result_nxt = {{(ADDR_W-BYTE_W){src_a[BYTE_W-1]}}, src_a[BYTE_W-1:0]};
        OP_ADDR_SIGN_EXT_HALF:
          result_nxt = {{(ADDR_W-HALF_W){src_a[HALF_W-1]}}, src_a[HALF_W-1:0]};
        OP_ADDR_ZERO_EXT_BYTE:
          result_nxt = {{(ADDR_W-BYTE_W){1'b0}}, src_a[BYTE_W-1:0]};
        OP_ADDR_ZERO_EXT_HALF:
          result_nxt = {{(ADDR_W-HALF_W){1'b0}}, src_a[HALF_W-1:0]};
        default: begin
          result_we_nxt = 1'b0;
          done_nxt      = 1'b0;
        end
      endcase
    end
  end

  // Clock enable low freezes every output, pulses included
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result_r    <= ADDR_ZERO;
      result_we_r <= 1'b0;
      true_flag_r <= FLAG_RST;
      done_r      <= 1'b0;
    end else if (clk_en) begin
      result_r    <= result_nxt;
      result_we_r <= result_we_nxt;
      true_flag_r <= true_flag_nxt;
      done_r      <= done_nxt;
    end
  end

  sequence issued_s(aga_op_t op);
    issue && op_code == op;
  endsequence

  sequence written_s;
    done_r && result_we_r;
  endsequence

  sequence flagged_s;
    done_r && !result_we_r;
  endsequence

  sequence linear_s;
    mod_mode == MODE_LINEAR;
  endsequence

  // Operands already inside the buffer, so one wrap is enough
  sequence mod_in_s;
    mod_mode == MODE_MODULO && src_a >= mod_base && src_a - mod_base < mod_len
      && src_b < mod_len;
  endsequence

  add_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_ADD) ##0 linear_s |=> written_s
      and result_r == $past(src_a) + $past(src_b))
    else $error("linear add result wrong");

  add_shift_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_ADD_SHIFT_TWO) ##0 linear_s |=>
      result_r == $past(src_a) + ($past(src_b) << SHIFT_TWO))
    else $error("add with two shift wrong");

  shift_left_two_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_ARITH_LEFT_TWO) |=> written_s
      and result_r == {$past(src_a[ADDR_W-3:0]), 2'b00})
    else $error("left shift by two wrong");

  shift_right_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_ARITH_RIGHT) |=> result_r[ADDR_W-1] == result_r[ADDR_W-2]
      && result_r[ADDR_W-2:0] == $past(src_a[ADDR_W-1:1]))
    else $error("arithmetic right shift wrong");

  logic_right_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_LOGIC_RIGHT) |=> written_s
      and result_r == {1'b0, $past(src_a[ADDR_W-1:1])})
    else $error("logical right shift wrong");

  dec_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_DEC_FLAG_ZERO) |=> true_flag_r == ($past(src_a) == ADDR_ONE)
      && result_r == $past(src_a) - ADDR_ONE)
    else $error("decrement zero flag wrong");

  dec_nonneg_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_DEC_FLAG_NONNEG) |=>
      true_flag_r == ($signed($past(src_a) - ADDR_ONE) >= 0))
    else $error("decrement nonnegative flag wrong");

  cmp_higher_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_COMPARE_HIGHER) |=> !result_we_r
      && true_flag_r == ($past(src_a) > $past(src_b)))
    else $error("unsigned compare wrong");

  test_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_TEST_ZERO_LOW_HALF) |=>
      true_flag_r == ($past(src_a[HALF_W-1:0]) == 16'h0000))
    else $error("low half zero test wrong");

  test_pos_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_TEST_POSITIVE) |=> true_flag_r == ($signed($past(src_a)) > 0))
    else $error("positive test wrong");

  sign_ext_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_SIGN_EXT_BYTE) |=>
      $signed(result_r) == $signed($past(src_a[BYTE_W-1:0])))
    else $error("byte sign extend wrong");

  flag_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    issue && op_code inside {OP_ADDR_ADD, OP_ADDR_ARITH_LEFT, OP_ADDR_ZERO_EXT_HALF,
      OP_ADDR_INC, OP_ADDR_SUB} |=> $stable(true_flag_r))
    else $error("flag changed by non flag op");

  add_shift_one_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_ADD_SHIFT_ONE) ##0 linear_s |=> written_s
      and result_r == $past(src_a) + ($past(src_b) << SHIFT_ONE))
    else $error("add with one shift wrong");

  mod_window_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_ADD) ##0 mod_in_s |=> written_s and result_r >= $past(mod_base)
      && result_r - $past(mod_base) < $past(mod_len))
    else $error("modulo add left the buffer");

  shift_left_one_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_ARITH_LEFT) |=> written_s
      and result_r == {$past(src_a[ADDR_W-2:0]), 1'b0})
    else $error("left shift by one wrong");

  dec_nonneg_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_DEC_FLAG_NONNEG) |=> written_s
      and result_r == $past(src_a) - ADDR_ONE)
    else $error("decrement result wrong");

  cmp_equal_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_COMPARE_EQUAL) |=> flagged_s
      and true_flag_r == ($past(src_a) == $past(src_b)))
    else $error("equal compare wrong");

  cmp_greater_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_COMPARE_GREATER) |=> flagged_s
      and true_flag_r == ($signed($past(src_a)) > $signed($past(src_b))))
    else $error("signed compare wrong");

  // Compares and tests must not touch the destination
  compare_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    issue && op_code inside {OP_ADDR_COMPARE_EQUAL, OP_ADDR_COMPARE_GREATER,
      OP_ADDR_TEST_ZERO, OP_ADDR_TEST_NONNEG} |=> flagged_s and $stable(result_r))
    else $error("compare or test wrote result");

  test_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_TEST_ZERO) |=> flagged_s
      and true_flag_r == ($past(src_a) == ADDR_ZERO))
    else $error("zero test wrong");

  test_nonneg_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_TEST_NONNEG) |=> flagged_s
      and true_flag_r == !$past(src_a[ADDR_W-1]))
    else $error("nonnegative test wrong");

  sign_half_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_SIGN_EXT_HALF) |=>
      $signed(result_r) == $signed($past(src_a[HALF_W-1:0])))
    else $error("half sign extend wrong");

  zero_byte_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_ZERO_EXT_BYTE) |=> result_r[ADDR_W-1:BYTE_W] == '0
      && result_r[BYTE_W-1:0] == $past(src_a[BYTE_W-1:0]))
    else $error("byte zero extend wrong");

  zero_half_a: assert property (@(posedge ref_clk) disable iff (rst)
    issued_s(OP_ADDR_ZERO_EXT_HALF) |=> result_r[ADDR_W-1:HALF_W] == '0
      && result_r[HALF_W-1:0] == $past(src_a[HALF_W-1:0]))
    else $error("half zero extend wrong");

  ext_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    issue && op_code inside {OP_ADDR_SIGN_EXT_BYTE, OP_ADDR_SIGN_EXT_HALF,
      OP_ADDR_ZERO_EXT_BYTE, OP_ADDR_ZERO_EXT_HALF} |=> written_s)
    else $error("extend did not write");

  flag_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    issue && op_code inside {OP_ADDR_ADD_SHIFT_ONE, OP_ADDR_ADD_SHIFT_TWO, OP_ADDR_DEC,
      OP_ADDR_TFR, OP_ADDR_ARITH_LEFT_TWO, OP_ADDR_ARITH_RIGHT, OP_ADDR_LOGIC_RIGHT,
      OP_ADDR_SIGN_EXT_BYTE, OP_ADDR_SIGN_EXT_HALF, OP_ADDR_ZERO_EXT_BYTE} |=>
      $stable(true_flag_r))
    else $error("flag changed by shift or extend");

  idle_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !op_valid |=> !done_r && !result_we_r && $stable(true_flag_r))
    else $error("outputs moved with no op");

  // A stalled core must see its last answer unchanged
  enable_freeze_a: assert property (@(posedge ref_clk) disable iff (rst)
    !clk_en |=> $stable(result_r) && $stable(true_flag_r) && $stable(done_r)
      && $stable(result_we_r))
    else $error("outputs moved while clock enable low");
endmodule

//--- aga_issue_model.sv
`timescale 1ns/1ps
module aga_issue_model (
  input  wire logic                       ref_clk,
  output logic                            op_valid,
  output aga_pkg::aga_op_t                op_code,
  output logic      [aga_pkg::ADDR_W-1:0] src_a,
  output logic      [aga_pkg::ADDR_W-1:0] src_b,
  output aga_pkg::aga_mode_t              mod_mode,
  output logic      [aga_pkg::ADDR_W-1:0] mod_base,
  output logic      [aga_pkg::ADDR_W-1:0] mod_len
);
  import aga_pkg::*;
  // Small modulo window so a few adds reach both wrap edges
  initial begin
    op_valid = 1'b0;
    op_code  = OP_ADDR_TFR;
    src_a    = 32'h00000000;
    src_b    = 32'h00000000;
    mod_mode = MODE_LINEAR;
    mod_base = 32'h00000100;
    mod_len  = 32'h00000010;
  end
  // Called at a falling edge; returns at the falling edge after the taking edge
  task automatic issue(input aga_op_t op, input logic [ADDR_W-1:0] a,
                       input logic [ADDR_W-1:0] b, input aga_mode_t m);
    op_valid = 1'b1;
    op_code  = op;
    src_a    = a;
    src_b    = b;
    mod_mode = m;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // Idle: op_valid low, src_a toggles every cycle and src_b once, so stale values cannot pass for real ones
  task automatic idle(input int n);
    op_valid = 1'b0;
    src_a    = ~src_a;
    src_b    = ~src_b;
    repeat (n) begin
      @(negedge ref_clk);
      src_a = ~src_a;
    end
  endtask
endmodule

//--- aga_arith_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module aga_arith_test;
  import aga_pkg::*;
  logic ref_clk, rst, clk_en, op_valid, result_we_r, true_flag_r, done_r, flag;
  aga_op_t                op_code;
  aga_mode_t              mod_mode;
  logic      [ADDR_W-1:0] src_a, src_b, mod_base, mod_len, result_r, last_res;
  int                     checked, n_mismatch, cycles;
  aga_arith i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .src_a(src_a), .src_b(src_b), .mod_mode(mod_mode),
    .mod_base(mod_base), .mod_len(mod_len), .result_r(result_r),
    .result_we_r(result_we_r), .true_flag_r(true_flag_r), .done_r(done_r));
  aga_issue_model i_iss (.ref_clk(ref_clk), .op_valid(op_valid), .op_code(op_code),
    .src_a(src_a), .src_b(src_b), .mod_mode(mod_mode), .mod_base(mod_base),
    .mod_len(mod_len));
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic run(input aga_op_t op, input logic [31:0] a, input logic [31:0] b,
                     input logic [31:0] er, input logic we, input logic ef,
                     input aga_mode_t m = MODE_LINEAR);
    i_iss.issue(op, a, b, m);
    `CHK("done", 1'b1, done_r)
    `CHK("write", we, result_we_r)
    `CHK("result", we ? er : last_res, result_r)
    `CHK("flag", ef, true_flag_r)
    if (we) last_res = er;
    flag = ef;
  endtask
  // Writing op, flag must hold
  task automatic wr(input aga_op_t op, input logic [31:0] a, input logic [31:0] b,
                    input logic [31:0] er, input aga_mode_t m = MODE_LINEAR);
    run(op, a, b, er, 1'b1, flag, m);
  endtask
  task automatic t_add();
    wr(OP_ADDR_ADD, 32'h10000004, 32'h0000000C, 32'h10000010);
    wr(OP_ADDR_ADD, 32'h8, 32'h8, 32'h4, MODE_REVERSE_CARRY);
    wr(OP_ADDR_ADD, 32'hC, 32'h4, 32'hA, MODE_REVERSE_CARRY);
    wr(OP_ADDR_ADD, 32'h10C, 32'h4, 32'h100, MODE_MODULO);
    wr(OP_ADDR_ADD, 32'h104, 32'h4, 32'h108, MODE_MODULO);
    wr(OP_ADDR_ADD_SHIFT_ONE, 32'h100, 32'h80000003, 32'h106);
    wr(OP_ADDR_ADD_SHIFT_ONE, 32'h104, 32'hFFFFFFFC, 32'h10C, MODE_MODULO);
    wr(OP_ADDR_ADD_SHIFT_TWO, 32'h100, 32'h40000003, 32'h10C);
    wr(OP_ADDR_ADD_SHIFT_TWO, 32'h10C, 32'h1, 32'h100, MODE_MODULO);
  endtask
  task automatic t_dec();
    run(OP_ADDR_DEC_FLAG_ZERO, 32'h1, 32'h0, 32'h0, 1'b1, 1'b1);
    run(OP_ADDR_DEC_FLAG_ZERO, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1, 1'b0);
    run(OP_ADDR_DEC_FLAG_NONNEG, 32'h1, 32'h0, 32'h0, 1'b1, 1'b1);
    run(OP_ADDR_DEC_FLAG_NONNEG, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1, 1'b0);
    run(OP_ADDR_DEC_FLAG_NONNEG, 32'h80000000, 32'h0, 32'h7FFFFFFF, 1'b1, 1'b1);
    run(OP_ADDR_DEC_FLAG_ZERO, 32'h2, 32'h0, 32'h1, 1'b1, 1'b0);
    run(OP_ADDR_DEC_FLAG_NONNEG, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1, 1'b0);
  endtask
  task automatic t_cmp();
    run(OP_ADDR_COMPARE_EQUAL, 32'h5, 32'h5, 32'h0, 1'b0, 1'b1);
    run(OP_ADDR_COMPARE_EQUAL, 32'h5, 32'h4, 32'h0, 1'b0, 1'b0);
    run(OP_ADDR_COMPARE_GREATER, 32'h1, 32'hFFFFFFFF, 32'h0, 1'b0, 1'b1);
    run(OP_ADDR_COMPARE_GREATER, 32'h5, 32'h5, 32'h0, 1'b0, 1'b0);
    run(OP_ADDR_COMPARE_HIGHER, 32'hFFFFFFFF, 32'h1, 32'h0, 1'b0, 1'b1);
    run(OP_ADDR_COMPARE_HIGHER, 32'h1, 32'hFFFFFFFF, 32'h0, 1'b0, 1'b0);
    run(OP_ADDR_TEST_ZERO, 32'h10000, 32'h0, 32'h0, 1'b0, 1'b0);
    run(OP_ADDR_TEST_ZERO, 32'h0, 32'h1, 32'h0, 1'b0, 1'b1);
    run(OP_ADDR_TEST_ZERO_LOW_HALF, 32'hABCD0000, 32'h0, 32'h0, 1'b0, 1'b1);
    run(OP_ADDR_TEST_ZERO_LOW_HALF, 32'h00010001, 32'h0, 32'h0, 1'b0, 1'b0);
    run(OP_ADDR_TEST_NONNEG, 32'h0, 32'h0, 32'h0, 1'b0, 1'b1);
    run(OP_ADDR_TEST_NONNEG, 32'h80000000, 32'h0, 32'h0, 1'b0, 1'b0);
    run(OP_ADDR_TEST_POSITIVE, 32'h0, 32'h0, 32'h0, 1'b0, 1'b0);
    run(OP_ADDR_TEST_POSITIVE, 32'h1, 32'h0, 32'h0, 1'b0, 1'b1);
  endtask
  // Flag is high here, so a stray flag write shows
  task automatic t_shift_ext();
    wr(OP_ADDR_ARITH_LEFT_TWO, 32'hC0000001, 32'h0, 32'h00000004);
    wr(OP_ADDR_ARITH_LEFT, 32'h40000001, 32'h0, 32'h80000002);
    wr(OP_ADDR_ARITH_RIGHT, 32'h80000002, 32'h0, 32'hC0000001);
    wr(OP_ADDR_LOGIC_RIGHT, 32'h80000003, 32'h0, 32'h40000001);
    wr(OP_ADDR_SIGN_EXT_BYTE, 32'h12345680, 32'h0, 32'hFFFFFF80);
    wr(OP_ADDR_SIGN_EXT_HALF, 32'h00008001, 32'h0, 32'hFFFF8001);
    wr(OP_ADDR_ZERO_EXT_BYTE, 32'hFFFFFF80, 32'h0, 32'h00000080);
    wr(OP_ADDR_ZERO_EXT_HALF, 32'hFFFF8001, 32'h0, 32'h00008001);
  endtask
  // Plain register ops, flag still high
  task automatic t_misc();
    wr(OP_ADDR_SUB, 32'h00000010, 32'h00000011, 32'hFFFFFFFF);
    wr(OP_ADDR_INC, 32'hFFFFFFFF, 32'h0, 32'h00000000);
    wr(OP_ADDR_DEC, 32'h00000000, 32'h0, 32'hFFFFFFFF);
    wr(OP_ADDR_TFR, 32'h12345678, 32'h0, 32'h12345678);
  endtask
  // Second reset mid-run, with result and flag nonzero going in
  task automatic t_reset();
    i_iss.idle(1);
    rst = 1'b1;
    @(negedge ref_clk);
    `CHK("result", 32'h00000000, result_r)
    `CHK("flag", FLAG_RST, true_flag_r)
    `CHK("done", 1'b0, done_r)
    `CHK("write", 1'b0, result_we_r)
    rst = 1'b0;
    last_res = 32'h00000000;
    flag = FLAG_RST;
    run(OP_ADDR_TEST_POSITIVE, 32'h1, 32'h0, 32'h0, 1'b0, 1'b1);
  endtask
  task automatic t_clk_en();
    clk_en = 1'b0;
    i_iss.idle(2);
    `CHK("done", 1'b1, done_r)
    i_iss.issue(OP_ADDR_ADD, 32'h1, 32'h1, MODE_LINEAR);
    `CHK("result", last_res, result_r)
    clk_en = 1'b1;
    i_iss.idle(1);
    `CHK("done", 1'b0, done_r)
    `CHK("result", last_res, result_r)
    `CHK("flag", flag, true_flag_r)
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Ceiling far above the roughly 55 cycles the scenarios need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    last_res = 32'h00000000;
    flag = FLAG_RST;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    `CHK("result", 32'h00000000, result_r)
    `CHK("flag", FLAG_RST, true_flag_r)
    `CHK("done", 1'b0, done_r)
    t_add();
    t_dec();
    t_cmp();
    t_shift_ext();
    t_misc();
    t_reset();
    t_clk_en();
    summarize();
  end
endmodule
